// ---- include/ras_map.svh ----
`ifndef RAS_MAP_SVH
`define RAS_MAP_SVH

// Stack geometry
`define RAS_DEPTH       8
`define RAS_PTR_W       3
`define RAS_CNT_W       4
`define RAS_CNT_FULL    4'h8
`define RAS_CNT_EMPTY   4'h0
`define RAS_PC_W        13

// Register map
`define RAS_ADR_W       8
`define RAS_STAT_OFS    8'h00
`define RAS_STAT_RST    8'h00
`define RAS_OSF_BIT     7
`define RAS_RSV_MSB     6
`define RAS_RSV_LSB     3
`define RAS_PTR_MSB     2

`endif

// ---- include/ras_pkg.sv ----
`include "ras_map.svh"

package ras_pkg;

  typedef enum logic [0:0] {
    RAS_WB_IDLE = 1'b0,
    RAS_WB_ACK  = 1'b1
  } ras_wb_state_t;

  typedef logic [`RAS_PC_W-1:0]  ras_pc_t;
  typedef logic [`RAS_PTR_W-1:0] ras_ptr_t;
  typedef logic [`RAS_CNT_W-1:0] ras_cnt_t;

  // Status register address decode
  function automatic logic ras_hit(input logic [`RAS_ADR_W-1:0] adr);
    ras_hit = (adr == `RAS_STAT_OFS);
  endfunction : ras_hit

endpackage : ras_pkg

// ---- logic/ras_stack_mem.sv ----
module ras_stack_mem
  import ras_pkg::*;
(
  // Clock and reset
  input  wire logic     clk_i,
  input  wire logic     rst_i,
  // Write side
  input  wire logic     wr_en_i,
  input  wire ras_ptr_t wr_idx_i,
  input  wire ras_pc_t  wr_data_i,
  // Read side
  input  wire ras_ptr_t rd_idx_i,
  output ras_pc_t       rd_data_o
);

  ras_pc_t entry [`RAS_DEPTH];

  genvar gi;
  generate
    for (gi = 0; gi < `RAS_DEPTH; gi++) begin : g_entry
      ras_pc_t next_entry;
      always_comb begin
        next_entry = entry[gi];
        if (wr_en_i && (wr_idx_i == ras_ptr_t'(gi))) begin
          next_entry = wr_data_i;
        end
      end
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          entry[gi] <= '0;
        end else begin
          entry[gi] <= next_entry;
        end
      end
    end
  endgenerate

  assign rd_data_o = entry[rd_idx_i];

  // Written entry holds its value
  entry_keep_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL1]
    wr_en_i ##1 (rd_idx_i == $past(wr_idx_i) && !wr_en_i) |-> rd_data_o == $past(wr_data_i))
    else $error("stack entry lost written value");

endmodule : ras_stack_mem

// ---- logic/ras_wb_slave.sv ----
module ras_wb_slave
  import ras_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [`RAS_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // Register side
  input  wire logic [7:0]            stat_i,
  output logic                       wr_o,
  output logic                       wr_data_o
);

  ras_wb_state_t state;
  ras_wb_state_t next_state;
  logic [31:0]   next_dat;

  always_comb begin
    next_state = state;
    next_dat   = wb_dat_o;
    case (state)
      RAS_WB_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          next_state = RAS_WB_ACK;
          next_dat   = (ras_hit(wb_adr_i) && !wb_we_i) ? {24'h000000, stat_i} : 32'h00000000;
        end
      end
      RAS_WB_ACK: begin
        next_state = RAS_WB_IDLE;
      end
      default: begin
        next_state = RAS_WB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state    <= RAS_WB_IDLE;
      wb_dat_o <= 32'h00000000;
    end else begin
      state    <= next_state;
      wb_dat_o <= next_dat;
    end
  end

  assign wb_ack_o  = (state == RAS_WB_ACK);
  // Write lands on the edge the master sees ack
  assign wr_o      = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && ras_hit(wb_adr_i) && wb_sel_i[0];
  assign wr_data_o = wb_dat_i[`RAS_OSF_BIT];

  ack_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  ack_latency_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack not given one cycle after request");

  read_layout_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL12]
    wb_ack_o |-> (wb_dat_o[`RAS_RSV_MSB:`RAS_RSV_LSB] == 4'h0 && wb_dat_o[31:8] == 24'h000000))
    else $error("reserved status bits not zero");

endmodule : ras_wb_slave

// ---- logic/ras_top.sv ----
// Overview of operation
// [RL1] Eight-entry stack holds program counter values only, not software addressable.
// [RL2] Three-bit level pointer selects active entry, readable in status register.
// [RL3] Call or interrupt acknowledge pushes the counter and advances the pointer.
// [RL4] Return or interrupt return reloads counter from stack, pointer steps back.
// [RL5] After reset pointer reads zero and overflow flag is cleared.
// [RL6] Stack full: interrupt stays pending, acknowledge withheld until a return.
// [RL7] Call on full stack still runs, overwriting the oldest saved counter.
// [RL8] Overflow flag sets on call when full or return when empty.
// [RL9] Overflow flag is sticky; only a software write of zero clears it.
// [RL10] Nine calls: pointer 1..7, 0, 1; flag rises on the ninth.
// [RL11] Eight returns from empty: pointer 7 down to 0; flag on first.
// [RL12] Status register: bit 7 flag read/write, bits 6..3 zero, 2..0 pointer.
// [RL13] Occupancy is counted apart from the wrapping pointer for full and empty.
//
// Chosen here: register access over Wishbone and the register offsets.
module ras_top
  import ras_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Sequencer requests
  input  wire logic                  call_i,
  input  wire logic                  return_from_subroutine_i,
  input  wire logic                  return_from_interrupt_i,
  input  wire logic                  int_req_i,
  input  wire ras_pc_t               pc_i,
  // Sequencer answers
  output logic                       int_ack_o,
  output ras_pc_t                    ret_pc_o,
  output logic                       ret_valid_o,
  output logic                       stack_full_o,
  // Wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [`RAS_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o
);

  ras_ptr_t stack_level_pointer;
  ras_ptr_t next_stack_level_pointer;
  ras_cnt_t depth_cnt;
  ras_cnt_t next_depth_cnt;
  logic     stack_overflow_flag;
  logic     next_stack_overflow_flag;
  logic     int_pend;
  logic     next_int_pend;
  logic     next_int_ack;
  ras_pc_t  next_ret_pc;
  logic     next_ret_valid;
  logic     next_stack_full;

  logic     ret_any;
  logic     call_go;
  logic     int_want;
  logic     ack_now;
  logic     push;
  logic     full;
  logic     empty;
  logic     osf_set;
  ras_ptr_t pop_idx;
  ras_pc_t  mem_rd;
  logic     sw_wr;
  logic     sw_wdata;
  logic [7:0] status;

  // Sequencer decode
  assign ret_any  = return_from_subroutine_i || return_from_interrupt_i;
  assign call_go  = call_i && !ret_any;
  assign int_want = int_pend || int_req_i;
  // [RL13] occupancy full and empty
  assign full     = (depth_cnt == `RAS_CNT_FULL);
  assign empty    = (depth_cnt == `RAS_CNT_EMPTY);
  // [RL6] acknowledge held off while full
  assign ack_now  = int_want && !full && !ret_any && !call_i;
  // [RL3] call or acknowledge pushes
  assign push     = call_go || ack_now;
  assign pop_idx  = stack_level_pointer - ras_ptr_t'(1);
  // [RL8] overflow causes
  assign osf_set  = (call_go && full) || (return_from_subroutine_i && empty);
  // [RL2] [RL12] status layout
  assign status   = {stack_overflow_flag, 4'h0, stack_level_pointer};

  // [RL1] dedicated storage, no software path
  ras_stack_mem u_mem (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .wr_en_i   (push),
    .wr_idx_i  (stack_level_pointer),
    .wr_data_i (pc_i),
    .rd_idx_i  (pop_idx),
    .rd_data_o (mem_rd)
  );

  ras_wb_slave u_wb (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .wb_cyc_i  (wb_cyc_i),
    .wb_stb_i  (wb_stb_i),
    .wb_we_i   (wb_we_i),
    .wb_adr_i  (wb_adr_i),
    .wb_sel_i  (wb_sel_i),
    .wb_dat_i  (wb_dat_i),
    .wb_dat_o  (wb_dat_o),
    .wb_ack_o  (wb_ack_o),
    .stat_i    (status),
    .wr_o      (sw_wr),
    .wr_data_o (sw_wdata)
  );

  // Pointer and occupancy
  always_comb begin
    next_stack_level_pointer = stack_level_pointer;
    next_depth_cnt           = depth_cnt;
    if (ret_any) begin
      // [RL4] [RL11] step back, wraps below zero
      next_stack_level_pointer = stack_level_pointer - ras_ptr_t'(1);
      if (!empty) begin
        next_depth_cnt = depth_cnt - ras_cnt_t'(1);
      end
    end else if (push) begin
      // [RL3] [RL10] advance, wraps past seven
      next_stack_level_pointer = stack_level_pointer + ras_ptr_t'(1);
      // [RL7] full push overwrites oldest entry
      if (!full) begin
        next_depth_cnt = depth_cnt + ras_cnt_t'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    // [RL5] pointer at zero, stack empty after reset
    if (rst_i) begin
      stack_level_pointer <= '0;
      depth_cnt           <= `RAS_CNT_EMPTY;
    end else begin
      stack_level_pointer <= next_stack_level_pointer;
      depth_cnt           <= next_depth_cnt;
    end
  end

  // Overflow flag
  always_comb begin
    next_stack_overflow_flag = stack_overflow_flag;
    // [RL9] sticky, hardware set beats software write
    if (osf_set) begin
      next_stack_overflow_flag = 1'b1;
    end else if (sw_wr) begin
      next_stack_overflow_flag = sw_wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stack_overflow_flag <= 1'(`RAS_STAT_RST >> `RAS_OSF_BIT);
    end else begin
      stack_overflow_flag <= next_stack_overflow_flag;
    end
  end

  // Sequencer answers
  always_comb begin
    // [RL6] request recorded until acknowledged
    next_int_pend   = (int_req_i || int_pend) && !ack_now;
    next_int_ack    = ack_now;
    next_ret_valid  = ret_any;
    next_ret_pc     = ret_pc_o;
    next_stack_full = full;
    // [RL4] reload counter from stack
    if (ret_any) begin
      next_ret_pc = mem_rd;
    end
    if (ret_any) begin
      next_stack_full = 1'b0;
    end else if (push) begin
      next_stack_full = full || (depth_cnt == `RAS_CNT_FULL - 4'h1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_pend     <= 1'b0;
      int_ack_o    <= 1'b0;
      ret_valid_o  <= 1'b0;
      ret_pc_o     <= '0;
      stack_full_o <= 1'b0;
    end else begin
      int_pend     <= next_int_pend;
      int_ack_o    <= next_int_ack;
      ret_valid_o  <= next_ret_valid;
      ret_pc_o     <= next_ret_pc;
      stack_full_o <= next_stack_full;
    end
  end

  // Checks
  sequence s_push;
    push && !ret_any;
  endsequence

  sequence s_push_pop;
    s_push ##1 ret_any;
  endsequence

  reset_state_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL5]
    $fell(rst_i) |-> (stack_level_pointer == 3'h0 && !stack_overflow_flag && empty))
    else $error("pointer or flag not clear after reset");

  push_step_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL3]
    s_push |=> stack_level_pointer == $past(stack_level_pointer) + 3'h1)
    else $error("push did not advance pointer");

  pop_step_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL4]
    ret_any |=> stack_level_pointer == $past(stack_level_pointer) - 3'h1)
    else $error("return did not step pointer back");

  pop_data_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL4]
    s_push_pop |=> (ret_valid_o && ret_pc_o == $past(pc_i, 2)))
    else $error("return gave wrong counter value");

  full_inhibit_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL6]
    (full && !ret_any) |=> !int_ack_o)
    else $error("interrupt acknowledged on full stack");

  ack_after_ret_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL6]
    (int_want && full && ret_any) ##1 (!call_i && !ret_any) |=> int_ack_o)
    else $error("pending interrupt not served after return");

  call_full_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL7]
    (call_go && full) |=> (full && stack_overflow_flag && stack_level_pointer == $past(stack_level_pointer) + 3'h1))
    else $error("call on full stack mishandled");

  ret_empty_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL11]
    (return_from_subroutine_i && empty) |=> (stack_overflow_flag && empty))
    else $error("return on empty stack did not flag");

  osf_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL9]
    (stack_overflow_flag && !sw_wr) |=> stack_overflow_flag)
    else $error("overflow flag dropped without software");

  osf_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL8]
    (!stack_overflow_flag && !osf_set && !sw_wr) |=> !stack_overflow_flag)
    else $error("overflow flag set without cause");

  count_track_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL13]
    (push && !ret_any && !full) |=> depth_cnt == $past(depth_cnt) + 4'h1)
    else $error("occupancy not counted on push");

  stat_ptr_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL2]
    (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i == `RAS_STAT_OFS)
      |=> wb_dat_o[`RAS_PTR_MSB:0] == $past(stack_level_pointer))
    else $error("status read does not show pointer");

  ptr_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL10]
    (call_go && stack_level_pointer == 3'h7) |=> stack_level_pointer == 3'h0)
    else $error("pointer did not wrap from seven to zero");

  ptr_under_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL11]
    (ret_any && stack_level_pointer == 3'h0) |=> stack_level_pointer == 3'h7)
    else $error("pointer did not wrap from zero to seven");

  ack_push_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL3]
    ack_now |=> (int_ack_o && stack_level_pointer == $past(stack_level_pointer) + 3'h1))
    else $error("acknowledge did not push");

  ack_cause_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL3]
    !int_want |=> !int_ack_o)
    else $error("acknowledge without request");

  ret_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL4]
    ret_any |=> ret_valid_o)
    else $error("return not reported");

  ret_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL4]
    !ret_any |=> (!ret_valid_o && $stable(ret_pc_o)))
    else $error("return output moved without return");

  full_out_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL13]
    stack_full_o == full)
    else $error("full output disagrees with occupancy");

  pend_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL6]
    (int_req_i && full && !ret_any) |=> int_pend)
    else $error("request on full stack not recorded");

  busy_no_ack_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL6]
    (call_i || ret_any) |=> !int_ack_o)
    else $error("acknowledge during call or return");

  sw_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL12]
    (sw_wr && !osf_set) |=> stack_overflow_flag == $past(sw_wdata))
    else $error("software write of flag lost");

  set_wins_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL9]
    osf_set |=> stack_overflow_flag)
    else $error("overflow cause did not set flag");

  occ_pop_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL13]
    (ret_any && !empty) |=> depth_cnt == $past(depth_cnt) - 4'h1)
    else $error("occupancy not counted on return");

endmodule : ras_top

// ---- test/ras_seq_model.sv ----
module ras_seq_model
  import ras_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Bench commands
  input  wire logic [2:0] op_i,
  input  wire ras_pc_t    pc_i,
  // Sequencer events
  output logic            call_o,
  output logic            sub_ret_o,
  output logic            int_ret_o,
  output logic            irq_o,
  output ras_pc_t         pc_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // One instruction event per cycle, idle low
  always_ff @(posedge clk_i) begin
    call_o    <= !rst_i && op_i == 3'h1;
    sub_ret_o <= !rst_i && op_i == 3'h2;
    int_ret_o <= !rst_i && op_i == 3'h3;
    irq_o     <= !rst_i && op_i == 3'h4;
    pc_o      <= pc_i;
  end
endmodule : ras_seq_model

// ---- test/return_address_stack_tb.sv ----
module return_address_stack_tb
  import ras_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [2:0]  op    = 3'h0;
  ras_pc_t     pc_req = '0;
  logic        call, sret, iret, irq, int_ack, ret_valid, full, ack;
  ras_pc_t     pc, ret_pc;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = '0, dat_o, rdat;
  int          err_total = 0, n_checks = 0, cycles = 0, acks = 0, rvs = 0;
  int          exp_acks = 0, exp_rvs = 0, cnt = 0;
  logic        flg = 1'b0, pend = 1'b0;
  ras_ptr_t    sp = '0;
  ras_pc_t     mem [8];

  initial forever #10 clk_i = ~clk_i;

  ras_seq_model u_seq (.clk_i(clk_i), .rst_i(rst_i), .op_i(op), .pc_i(pc_req), .call_o(call),
    .sub_ret_o(sret), .int_ret_o(iret), .irq_o(irq), .pc_o(pc));

  ras_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .call_i(call), .return_from_subroutine_i(sret),
    .return_from_interrupt_i(iret), .int_req_i(irq), .pc_i(pc), .int_ack_o(int_ack),
    .ret_pc_o(ret_pc), .ret_valid_o(ret_valid), .stack_full_o(full), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack));

  always @(posedge clk_i) begin
    cycles++;
    if (int_ack === 1'b1) acks++;
    if (ret_valid === 1'b1) rvs++;
    if (cycles == 20000) begin
      err_total++;
      conclude();
    end
  end

  function automatic logic [31:0] exp_stat(input logic f, input ras_ptr_t p);
    return {24'h0, f, 4'h0, p};
  endfunction : exp_stat

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rdat = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 50) err_total++;
  endtask : wb

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    sp = '0; cnt = 0; flg = 1'b0; pend = 1'b0;
  endtask : do_reset

  task automatic do_op(input int k, input ras_pc_t p);
    logic    popped;
    ras_pc_t want;
    popped = 1'b0;
    @(posedge clk_i);
    op <= k[2:0]; pc_req <= p;
    @(posedge clk_i);
    op <= 3'h0;
    repeat (4) @(posedge clk_i);
    #1;
    if (k == 1 || (k == 4 && cnt < 8)) begin
      if (k == 1 && cnt == 8) flg = 1'b1;
      mem[sp] = p; sp++;
      if (cnt < 8) cnt++;
      if (k == 4) exp_acks++;
    end else if (k == 4) pend = 1'b1;
    else begin
      if (k == 2 && cnt == 0) flg = 1'b1;
      sp--; want = mem[sp]; popped = cnt > 0; exp_rvs++;
      if (cnt > 0) cnt--;
      if (pend) begin
        mem[sp] = p; sp++; cnt++; pend = 1'b0; exp_acks++;
      end
    end
    if (popped) check("ret_pc", {19'h0, ret_pc}, {19'h0, want});
    check("int_ack count", acks, exp_acks);
    check("ret_valid count", rvs, exp_rvs);
    check("stack_full", {31'h0, full}, {31'h0, cnt == 8});
    wb(1'b0, 8'h00, 4'hF, '0);
    check("status", rdat, exp_stat(flg, sp));
  endtask : do_op

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  initial begin
    void'($urandom(32'h3212));
    do_reset();
    wb(1'b0, 8'h00, 4'hF, '0);
    check("status after reset", rdat, exp_stat(1'b0, 3'h0));
    for (int i = 0; i < 9; i++) do_op(1, ras_pc_t'($urandom));
    do_op(4, ras_pc_t'($urandom));
    do_op(3, ras_pc_t'($urandom));
    for (int i = 0; i < 8; i++) do_op(2, ras_pc_t'($urandom));
    // Ignored writes: no byte enable, unmapped place
    wb(1'b1, 8'h00, 4'h0, '0);
    wb(1'b1, 8'h04, 4'hF, '0);
    wb(1'b0, 8'h00, 4'hF, '0);
    check("status kept", rdat, exp_stat(flg, sp));
    wb(1'b0, 8'h04, 4'hF, '0);
    check("unmapped read", rdat, '0);
    wb(1'b1, 8'h00, 4'hF, '0);
    flg = 1'b0;
    wb(1'b0, 8'h00, 4'hF, '0);
    check("flag cleared", rdat, exp_stat(flg, sp));
    wb(1'b1, 8'h00, 4'hF, 32'h0000_00FF);
    flg = 1'b1;
    wb(1'b0, 8'h00, 4'hF, '0);
    check("read-only bits", rdat, exp_stat(flg, sp));
    do_reset();
    for (int i = 0; i < 8; i++) do_op(2, ras_pc_t'($urandom));
    for (int i = 0; i < 80; i++) do_op(1 + $urandom_range(3), ras_pc_t'($urandom));
    // Back-to-back call then return after a fresh reset
    do_reset();
    @(posedge clk_i);
    op <= 3'h1;
    pc_req <= ras_pc_t'($urandom);
    @(posedge clk_i);
    op <= 3'h2;
    @(posedge clk_i);
    op <= 3'h0;
    repeat (4) @(posedge clk_i);
    #1;
    exp_rvs++;
    check("b2b ret_pc", {19'h0, ret_pc}, {19'h0, pc_req});
    check("b2b ret_valid count", rvs, exp_rvs);
    wb(1'b0, 8'h00, 4'hF, '0);
    check("b2b status", rdat, exp_stat(1'b0, 3'h0));
    conclude();
  end
endmodule : return_address_stack_tb
